//--- relative_position_loop.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE1] Scale every feedback to -1000..+1000
// [RULE2] Analog/pulse scaling uses min, max, center
// [RULE3] Encoder scaling uses low/high count limits
// [RULE4] Encoder count trusted only after homing
// [RULE5] Loop error holds channel stopped until cleared
// [RULE6] Configurable feedback polarity inversion
// [RULE7] Any selected digital input stops channel
// [RULE8] Current over threshold too long fires action
// [RULE9] Moves follow accel, cruise, decel profile
// [RULE10] Profile defaults at reset, runtime writable
// [RULE11] Analog/pulse use turn span for speed, turns
// [RULE12] Encoder gives speed and turns directly
// [RULE13] Each millisecond compare setpoint, correct power
// [RULE14] Host never commands beyond sensor travel
// [RULE15] Command from link, analog or pulse input
// [RULE16] Loop error by time and size pair
// [RULE17] Saturate feedback outside calibrated range
// [RULE18] Hold destination once target reached
module relative_position_loop #(
  parameter int TICK_CYCLES = pos_loop_pkg::TICK_CYC,
  parameter logic [15:0] DEF_ACC = pos_loop_pkg::NV_ACC,
  parameter logic [15:0] DEF_DEC = pos_loop_pkg::NV_DEC,
  parameter logic [15:0] DEF_VEL = pos_loop_pkg::NV_VEL
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor and command inputs, asynchronous
  input wire logic [11:0] ana_fb,
  input wire logic [11:0] pls_fb,
  input wire logic [11:0] cmd_ana,
  input wire logic [11:0] cmd_pls,
  input wire logic [11:0] cur_sense,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic home_sw,
  input wire logic [7:0] limit_in,
  // Motor drive and interrupt
  output logic signed [11:0] motor_power,
  output logic motor_halt,
  output logic irq
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [70:0] s1;
    logic [70:0] s2;
    logic [1:0] ab;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic [8:0] ctrl;
    logic signed [11:0] cmd;
    logic [31:0] cmin;
    logic [31:0] cmax;
    logic [31:0] cctr;
    logic [31:0] elo;
    logic [31:0] ehi;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] vmax;
    logic [15:0] turns;
    logic [11:0] cthr;
    logic [15:0] cms;
    logic [7:0] lsel;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [15:0] tcnt;
    logic tick;
    logic signed [31:0] enc;
    logic signed [31:0] enc_p;
    logic homed;
    logic signed [11:0] fb;
    logic signed [11:0] fb_p;
    logic signed [11:0] tgt;
    logic signed [23:0] pos;
    logic [15:0] vm;
    logic busy;
    logic lerr;
    logic [10:0] lcnt;
    logic estop;
    logic slim;
    logic lim;
    logic [15:0] ccnt;
    logic signed [31:0] speed;
    logic signed [31:0] turn;
    logic signed [11:0] pwr;
    logic halt;
    logic irq;
  } state_t;

  state_t q, d;

  // ------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------
  function automatic logic signed [11:0] scale(
    input logic signed [31:0] raw,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi,
    input logic signed [31:0] ctr);
    logic signed [47:0] n;
    logic signed [47:0] r;
    n = 48'(raw) - 48'(ctr);
    r = '0;
    if (raw <= lo) begin
      scale = -12'sd1000; // RULE17
    end else if (raw >= hi) begin
      scale = 12'sd1000; // RULE17
    end else begin
      // Center splits the span in two halves of their own slope
      if (raw >= ctr) begin
        r = (n * 48'sd1000) / (48'(hi) - 48'(ctr));
      end else begin
        r = (n * 48'sd1000) / (48'(ctr) - 48'(lo));
      end
      scale = 12'(r);
    end
  endfunction

  function automatic logic signed [31:0] ext(input logic [11:0] v);
    ext = {20'h0, v};
  endfunction

  function automatic logic signed [11:0] clamp(
    input logic signed [31:0] v);
    if (v > 32'sd1000) clamp = 12'sd1000;
    else if (v < -32'sd1000) clamp = -12'sd1000;
    else clamp = 12'(v);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic acc_ph, wr, rd_clr, mapped, home_wr, lim_now, stop;
  logic signed [11:0] fb_raw, src_cmd, sp, lthr;
  logic signed [23:0] rem, arem;
  logic signed [12:0] err_v;
  logic [16:0] vn;
  logic [10:0] lms;
  logic [3:0] ev;
  logic [31:0] rd_val;

  always_comb begin
    d = q;
    ev = 4'h0;
    d.s1 = {limit_in, home_sw, enc_b, enc_a, cur_sense, cmd_pls, cmd_ana,
            pls_fb, ana_fb};
    d.s2 = q.s1;
    d.ab = q.s2[61:60];

    // Register access
    acc_ph = psel && penable && q.rdy;
    wr = acc_ph && pwrite;
    rd_clr = acc_ph && !pwrite && paddr == pos_loop_pkg::A_STAT;
    home_wr = wr && paddr == pos_loop_pkg::A_CTRL &&
              pwdata[pos_loop_pkg::C_HOME];
    mapped = paddr <= pos_loop_pkg::A_TURN && paddr[1:0] == 2'h0;
    case (paddr)
      pos_loop_pkg::A_CTRL: rd_val = {23'h0, q.ctrl};
      pos_loop_pkg::A_CMD: rd_val = 32'(q.cmd);
      pos_loop_pkg::A_CMIN: rd_val = q.cmin;
      pos_loop_pkg::A_CMAX: rd_val = q.cmax;
      pos_loop_pkg::A_CCTR: rd_val = q.cctr;
      pos_loop_pkg::A_ELO: rd_val = q.elo;
      pos_loop_pkg::A_EHI: rd_val = q.ehi;
      pos_loop_pkg::A_ACC: rd_val = {16'h0, q.acc};
      pos_loop_pkg::A_DEC: rd_val = {16'h0, q.dec};
      pos_loop_pkg::A_VEL: rd_val = {16'h0, q.vmax};
      pos_loop_pkg::A_TURNS: rd_val = {16'h0, q.turns};
      pos_loop_pkg::A_CTHR: rd_val = {20'h0, q.cthr};
      pos_loop_pkg::A_CMS: rd_val = {16'h0, q.cms};
      pos_loop_pkg::A_LSEL: rd_val = {24'h0, q.lsel};
      pos_loop_pkg::A_STAT: rd_val = {22'h0, q.homed, q.halt, q.estop,
                                      q.lim, q.lerr, q.busy, q.stat};
      pos_loop_pkg::A_MASK: rd_val = {28'h0, q.mask};
      pos_loop_pkg::A_FB: rd_val = 32'(q.fb);
      pos_loop_pkg::A_SETP: rd_val = 32'(q.pos >>> 8);
      pos_loop_pkg::A_SPEED: rd_val = q.speed;
      pos_loop_pkg::A_ENC: rd_val = q.enc;
      pos_loop_pkg::A_TURN: rd_val = q.turn;
      default: rd_val = 32'h0;
    endcase
    d.rdy = psel && !penable;
    if (psel && !penable) begin
      d.rdata = rd_val;
      d.err = !mapped;
    end else begin
      d.err = 1'b0;
    end
    if (wr) begin
      case (paddr)
        pos_loop_pkg::A_CTRL: d.ctrl = pwdata[8:0];
        pos_loop_pkg::A_CMD: d.cmd = clamp(pwdata); // RULE15
        pos_loop_pkg::A_CMIN: d.cmin = pwdata;
        pos_loop_pkg::A_CMAX: d.cmax = pwdata;
        pos_loop_pkg::A_CCTR: d.cctr = pwdata;
        pos_loop_pkg::A_ELO: d.elo = pwdata;
        pos_loop_pkg::A_EHI: d.ehi = pwdata;
        pos_loop_pkg::A_ACC: d.acc = pwdata[15:0]; // RULE10
        pos_loop_pkg::A_DEC: d.dec = pwdata[15:0]; // RULE10
        pos_loop_pkg::A_VEL: d.vmax = pwdata[15:0]; // RULE10
        pos_loop_pkg::A_TURNS: d.turns = pwdata[15:0];
        pos_loop_pkg::A_CTHR: d.cthr = pwdata[11:0];
        pos_loop_pkg::A_CMS: d.cms = pwdata[15:0];
        pos_loop_pkg::A_LSEL: d.lsel = pwdata[7:0];
        pos_loop_pkg::A_MASK: d.mask = pwdata[3:0];
        default: ;
      endcase
    end

    // ------------------------------------------------------------
    // Millisecond tick and encoder
    // ------------------------------------------------------------
    d.tick = 1'b0;
    if (q.tcnt == 16'(TICK_CYCLES - 1)) begin
      d.tcnt = 16'h0;
      d.tick = 1'b1;
    end else begin
      d.tcnt = q.tcnt + 16'h1;
    end
    case ({q.ab, q.s2[61:60]})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: d.enc = q.enc + 32'sd1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: d.enc = q.enc - 32'sd1;
      default: ;
    endcase
    // Count is relative to power-up until homed
    if (q.s2[62] || home_wr) begin
      d.enc = 32'sh0; // RULE4
      d.homed = 1'b1; // RULE4
    end

    // ------------------------------------------------------------
    // Feedback and command scaling
    // ------------------------------------------------------------
    case (q.ctrl[pos_loop_pkg::C_SNS +: 2])
      pos_loop_pkg::SNS_PLS:
        fb_raw = scale(ext(q.s2[23:12]), q.cmin, q.cmax, q.cctr); // RULE2
      pos_loop_pkg::SNS_ENC:
        fb_raw = scale(q.enc, q.elo, q.ehi,
                       32'((33'($signed(q.elo)) +
                            33'($signed(q.ehi))) >>> 1)); // RULE3
      default:
        fb_raw = scale(ext(q.s2[11:0]), q.cmin, q.cmax, q.cctr); // RULE2
    endcase
    // Polarity fix for sensor and motor wired against each other
    d.fb = q.ctrl[pos_loop_pkg::C_INV] ? -fb_raw : fb_raw; // RULE6 RULE1
    case (q.ctrl[pos_loop_pkg::C_SRC +: 2])
      pos_loop_pkg::SRC_ANA:
        src_cmd = scale(ext(q.s2[35:24]), q.cmin, q.cmax, q.cctr); // RULE15
      pos_loop_pkg::SRC_PLS:
        src_cmd = scale(ext(q.s2[47:36]), q.cmin, q.cmax, q.cctr); // RULE15
      default: src_cmd = q.cmd;
    endcase
    d.tgt = src_cmd;
    if (src_cmd != q.tgt) d.busy = 1'b1;

    // ------------------------------------------------------------
    // Protection
    // ------------------------------------------------------------
    lim_now = |(q.s2[70:63] & q.lsel); // RULE7
    d.lim = lim_now || q.slim;
    if (d.lim && !q.lim) ev[pos_loop_pkg::ST_LIM] = 1'b1;
    stop = !q.ctrl[pos_loop_pkg::C_EN] || q.lerr || q.estop || q.lim ||
           (q.ctrl[pos_loop_pkg::C_SNS +: 2] == pos_loop_pkg::SNS_ENC &&
            !q.homed); // RULE5 RULE7 RULE4
    d.halt = stop;
    sp = 12'(q.pos >>> 8);
    err_v = 13'(sp) - 13'(q.fb);
    case (q.ctrl[pos_loop_pkg::C_ERR +: 2])
      2'h1: begin
        lthr = 12'(pos_loop_pkg::LERR_TH1);
        lms = 11'(pos_loop_pkg::LERR_MS1);
      end
      2'h2: begin
        lthr = 12'(pos_loop_pkg::LERR_TH2);
        lms = 11'(pos_loop_pkg::LERR_MS2);
      end
      2'h3: begin
        lthr = 12'(pos_loop_pkg::LERR_TH3);
        lms = 11'(pos_loop_pkg::LERR_MS3);
      end
      default: begin
        lthr = 12'sd2047;
        lms = 11'h7ff;
      end
    endcase

    // ------------------------------------------------------------
    // Millisecond loop: profile, error watch, current, speed
    // ------------------------------------------------------------
    rem = {{4{q.tgt[11]}}, q.tgt, 8'h0} - q.pos;
    arem = rem < 0 ? -rem : rem;
    vn = 17'h0;
    if (q.tick) begin
      if (!q.ctrl[pos_loop_pkg::C_EN]) begin
        // Open loop: setpoint follows feedback, no stale move
        d.pos = {{4{q.fb[11]}}, q.fb, 8'h0};
        d.vm = 16'h0;
        d.busy = 1'b0;
        d.lerr = 1'b0; // RULE5
        d.lcnt = 11'h0;
        d.estop = 1'b0;
      end else if (stop) begin
        d.vm = 16'h0;
      end else if (q.busy) begin
        // Brake once v^2 reaches 2*dec*distance
        if (48'(q.vm) * 48'(q.vm) >=
            48'({q.dec, 1'b0}) * 48'(arem)) begin
          vn = q.vm > q.dec ? 17'(q.vm - q.dec) : 17'h1; // RULE9
        end else begin
          vn = 17'(q.vm) + 17'(q.acc); // RULE9
          if (vn > 17'(q.vmax)) vn = 17'(q.vmax);
        end
        if (vn == 17'h0) vn = 17'h1;
        if (arem <= 24'(vn)) begin
          d.pos = {{4{q.tgt[11]}}, q.tgt, 8'h0}; // RULE18
          d.vm = 16'h0;
          d.busy = 1'b0;
          ev[pos_loop_pkg::ST_DONE] = 1'b1;
        end else begin
          d.vm = vn[15:0];
          d.pos = rem < 0 ? q.pos - 24'(vn) : q.pos + 24'(vn); // RULE13
        end
      end
      if (q.ctrl[pos_loop_pkg::C_EN]) begin
        if (err_v > 13'(lthr) || err_v < -13'(lthr)) begin
          if (q.lcnt >= lms - 11'h1) begin
            d.lerr = 1'b1; // RULE16
            if (!q.lerr) ev[pos_loop_pkg::ST_LERR] = 1'b1;
          end else begin
            d.lcnt = q.lcnt + 11'h1;
          end
        end else begin
          d.lcnt = 11'h0;
          d.lerr = 1'b0; // RULE5
        end
      end
      if (q.s2[59:48] >= q.cthr) begin
        if (q.ccnt >= q.cms) begin
          if (!q.estop && !q.slim) ev[pos_loop_pkg::ST_CUR] = 1'b1;
          if (q.ctrl[pos_loop_pkg::C_ACT]) d.slim = 1'b1; // RULE8
          else d.estop = 1'b1; // RULE8
        end else begin
          d.ccnt = q.ccnt + 16'h1;
        end
      end else begin
        d.ccnt = 16'h0;
        d.slim = 1'b0;
      end
      d.enc_p = q.enc;
      d.fb_p = q.fb;
      if (q.ctrl[pos_loop_pkg::C_SNS +: 2] == pos_loop_pkg::SNS_ENC) begin
        d.speed = q.enc - q.enc_p; // RULE12
        d.turn = q.enc; // RULE12
      end else begin
        // Span covers 2000 feedback units, result in milli-turns
        d.speed = (32'(q.fb) - 32'(q.fb_p)) *
                  $signed(32'(q.turns)) >>> 1; // RULE11
        d.turn = (32'(q.fb) + 32'(pos_loop_pkg::FB_SPAN)) *
                 32'(q.turns) >>> 1; // RULE11
      end
    end

    // Proportional correction, zeroed while the channel is stopped
    d.pwr = stop ? 12'sh0 :
            clamp(32'(err_v) <<< pos_loop_pkg::KP_SHIFT); // RULE13

    // ------------------------------------------------------------
    // Interrupt status: set wins over read clear
    // ------------------------------------------------------------
    d.stat = (rd_clr ? 4'h0 : q.stat) | ev;
    d.irq = |(d.stat & q.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= pos_loop_pkg::RST_CTRL;
      q.cmin <= pos_loop_pkg::RST_CMIN;
      q.cmax <= pos_loop_pkg::RST_CMAX;
      q.cctr <= pos_loop_pkg::RST_CCTR;
      q.elo <= pos_loop_pkg::RST_ELO;
      q.ehi <= pos_loop_pkg::RST_EHI;
      q.acc <= DEF_ACC; // RULE10
      q.dec <= DEF_DEC; // RULE10
      q.vmax <= DEF_VEL; // RULE10
      q.turns <= pos_loop_pkg::RST_TURNS;
      q.cthr <= pos_loop_pkg::RST_CTHR;
      q.cms <= pos_loop_pkg::RST_CMS;
      q.halt <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign motor_power = q.pwr;
  assign motor_halt = q.halt;
  assign irq = q.irq;
endmodule
`default_nettype wire

//--- pos_loop_pkg.sv
`default_nettype none
package pos_loop_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int LERR_MS1 = 250;
  localparam int LERR_MS2 = 500;
  localparam int LERR_MS3 = 1000;
  localparam int LERR_TH1 = 100;
  localparam int LERR_TH2 = 250;
  localparam int LERR_TH3 = 500;
  localparam int FB_SPAN = 1000;
  localparam int KP_SHIFT = 2;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_CMIN = 8'h08;
  localparam logic [7:0] A_CMAX = 8'h0c;
  localparam logic [7:0] A_CCTR = 8'h10;
  localparam logic [7:0] A_ELO = 8'h14;
  localparam logic [7:0] A_EHI = 8'h18;
  localparam logic [7:0] A_ACC = 8'h1c;
  localparam logic [7:0] A_DEC = 8'h20;
  localparam logic [7:0] A_VEL = 8'h24;
  localparam logic [7:0] A_TURNS = 8'h28;
  localparam logic [7:0] A_CTHR = 8'h2c;
  localparam logic [7:0] A_CMS = 8'h30;
  localparam logic [7:0] A_LSEL = 8'h34;
  localparam logic [7:0] A_STAT = 8'h38;
  localparam logic [7:0] A_MASK = 8'h3c;
  localparam logic [7:0] A_FB = 8'h40;
  localparam logic [7:0] A_SETP = 8'h44;
  localparam logic [7:0] A_SPEED = 8'h48;
  localparam logic [7:0] A_ENC = 8'h4c;
  localparam logic [7:0] A_TURN = 8'h50;
  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int C_EN = 0;
  localparam int C_INV = 1;
  localparam int C_SNS = 2;
  localparam int C_ERR = 4;
  localparam int C_SRC = 6;
  localparam int C_ACT = 8;
  localparam int C_HOME = 9;
  localparam logic [1:0] SNS_ANA = 2'h0;
  localparam logic [1:0] SNS_PLS = 2'h1;
  localparam logic [1:0] SNS_ENC = 2'h2;
  localparam logic [1:0] SRC_LINK = 2'h0;
  localparam logic [1:0] SRC_ANA = 2'h1;
  localparam logic [1:0] SRC_PLS = 2'h2;
  localparam int ST_DONE = 0;
  localparam int ST_LERR = 1;
  localparam int ST_LIM = 2;
  localparam int ST_CUR = 3;
  // ------------------------------------------------------------
  // Reset values (non-volatile defaults)
  // ------------------------------------------------------------
  localparam logic [8:0] RST_CTRL = 9'h000;
  localparam logic [31:0] RST_CMIN = 32'h0000_0000;
  localparam logic [31:0] RST_CMAX = 32'h0000_0fff;
  localparam logic [31:0] RST_CCTR = 32'h0000_0800;
  localparam logic [31:0] RST_ELO = 32'hffff_fc18;
  localparam logic [31:0] RST_EHI = 32'h0000_03e8;
  localparam logic [15:0] NV_ACC = 16'h0010;
  localparam logic [15:0] NV_DEC = 16'h0010;
  localparam logic [15:0] NV_VEL = 16'h0400;
  localparam logic [15:0] RST_TURNS = 16'h000a;
  localparam logic [11:0] RST_CTHR = 12'hfff;
  localparam logic [15:0] RST_CMS = 16'h0064;
endpackage
`default_nettype wire

//--- pos_loop_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pos_loop_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Motor
  input wire logic signed [11:0] motor_power,
  input wire logic motor_halt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  logic bad_a;
  assign setup = psel && !penable;
  // Misaligned words count as unmapped, no byte lanes exist
  assign bad_a = (paddr > 8'h50) || (paddr[1:0] != 2'h0);
  a_rdy_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_rdy_idle: assert property (!psel |=> !pready)
    else $error("ready without select");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmap: assert property (setup && bad_a |=> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (setup && !bad_a |=> !pslverr)
    else $error("mapped access refused");
  a_rd_unmap: assert property (setup && bad_a && !pwrite |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_halt_quiet:
    assert property (motor_halt |-> motor_power == 12'sh000)
    else $error("power while halted");
  a_power_span:
    assert property (motor_power <= 12'sh3e8 && motor_power >= -12'sh3e8)
    else $error("power out of span");
endmodule
bind relative_position_loop pos_loop_sva pos_loop_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .motor_power(motor_power), .motor_halt(motor_halt));
`default_nettype wire

//--- motor_plant.sv
`timescale 1ns/10ps
`default_nettype none
module motor_plant #(
  parameter int STEP_CYC = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drive
  input wire logic signed [11:0] motor_power,
  input wire logic motor_halt,
  // Bench control
  input wire logic stall,
  input wire logic ovr_en,
  input wire logic [11:0] ovr_raw,
  // Sensor
  output logic [11:0] ana_fb
);
  int cnt_q;
  int pos_q;
  int nxt;
  always_comb nxt = pos_q + (motor_halt ? 0 : int'(motor_power) / 8);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 0;
      pos_q <= 32'h800;
    end else if (ovr_en) begin
      pos_q <= int'(ovr_raw);
    end else begin
      cnt_q <= (cnt_q == STEP_CYC - 1) ? 0 : cnt_q + 1;
      // A jammed axle ignores drive entirely
      if (cnt_q == STEP_CYC - 1 && !stall) begin
        // Pot cannot travel past its ends
        pos_q <= nxt < 0 ? 0 : (nxt > 4095 ? 4095 : nxt);
      end
    end
  end
  assign ana_fb = 12'(pos_q);
endmodule
`default_nettype wire

//--- relative_position_loop_tb.sv
`timescale 1ns/10ps
`default_nettype none
module relative_position_loop_tb;
  localparam int TK = 20;
  typedef struct packed {logic [7:0] a; logic [31:0] v; logic e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, limit_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, q;
  logic pready, pslverr, motor_halt, irq, e, stall = 0, ovr_en = 1;
  logic enc_a = 0, enc_b = 0, home_sw = 0;
  logic [11:0] ana_fb, cur_sense = 12'h000, ovr_raw = 12'h800;
  logic signed [11:0] motor_power;
  int bad_count = 0, checks_done = 0;
  row_t rows [14] = '{'{8'h00, 32'h0, 1'b0}, '{8'h08, 32'h0, 1'b0},
    '{8'h0c, 32'hfff, 1'b0}, '{8'h10, 32'h800, 1'b0},
    '{8'h14, 32'hffff_fc18, 1'b0}, '{8'h18, 32'h3e8, 1'b0},
    '{8'h1c, 32'h10, 1'b0}, '{8'h20, 32'h10, 1'b0},
    '{8'h24, 32'h400, 1'b0}, '{8'h28, 32'ha, 1'b0},
    '{8'h2c, 32'hfff, 1'b0}, '{8'h30, 32'h64, 1'b0},
    '{8'h54, 32'h0, 1'b1}, '{8'h02, 32'h0, 1'b1}};
  always #10 pclk = ~pclk;
  relative_position_loop #(.TICK_CYCLES(TK)) relative_position_loop_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ana_fb(ana_fb),
    .pls_fb(ana_fb), .cmd_ana(12'h800), .cmd_pls(12'h800),
    .cur_sense(cur_sense), .enc_a(enc_a), .enc_b(enc_b),
    .home_sw(home_sw), .limit_in(limit_in), .motor_power(motor_power),
    .motor_halt(motor_halt), .irq(irq));
  motor_plant #(.STEP_CYC(TK)) motor_plant_inst (
    .pclk(pclk), .presetn(presetn), .motor_power(motor_power),
    .motor_halt(motor_halt), .stall(stall), .ovr_en(ovr_en),
    .ovr_raw(ovr_raw), .ana_fb(ana_fb));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chkv(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, g, x);
    end
  endtask
  task automatic chkb(input logic g, input logic x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // Bounded wait for halt (w=1) or interrupt (w=0)
  task automatic wait_hi(input logic w, input int n);
    while ((w ? motor_halt : irq) !== 1'b1 && n > 0) begin
      @(posedge pclk);
      n--;
    end
    if (n == 0) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic fb_at(input logic [11:0] raw, input logic [31:0] x);
    ovr_raw <= raw;
    cyc(6);
    rd(8'h40);
    chkv(r, x);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(16);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chkv(r, rows[i].v);
      chkb(e, rows[i].e);
    end
    $display("test reset values done");
    fb_at(12'h800, 32'h0);
    cyc(TK);
    rd(8'h50);
    chkv(r, 32'h1388);
    fb_at(12'hfff, 32'h3e8);
    fb_at(12'h000, 32'hffff_fc18);
    wr(8'h08, 32'h100);
    fb_at(12'h080, 32'hffff_fc18);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h2);
    fb_at(12'hfff, 32'hffff_fc18);
    wr(8'h00, 32'h6);
    fb_at(12'h000, 32'h3e8);
    wr(8'h00, 32'h0);
    ovr_raw <= 12'h800;
    cyc(4);
    ovr_en <= 1'b0;
    $display("test scaling done");
    wr(8'h1c, 32'h100);
    rd(8'h1c);
    chkv(r, 32'h100);
    wr(8'h3c, 32'h1);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'hc8);
    cyc(10 * TK);
    rd(8'h44);
    chkb($signed(r) > 0 && $signed(r) < 200, 1'b1);
    chkb(motor_power > 12'sh0, 1'b1);
    wait_hi(1'b0, 800 * TK);
    rd(8'h38);
    chkv(r & 32'h1, 32'h1);
    rd(8'h44);
    chkv(r, 32'hc8);
    cyc(2);
    chkb(irq, 1'b0);
    $display("test move done");
    wr(8'h34, 32'h4);
    wr(8'h3c, 32'h4);
    limit_in <= 8'h20;
    cyc(6);
    chkb(motor_halt, 1'b0);
    limit_in <= 8'h04;
    cyc(6);
    chkb(motor_halt, 1'b1);
    chkb(irq, 1'b1);
    rd(8'h38);
    chkv(r & 32'h44, 32'h44);
    limit_in <= 8'h00;
    cyc(6);
    chkb(motor_halt, 1'b0);
    $display("test limit done");
    wr(8'h2c, 32'h400);
    wr(8'h30, 32'h3);
    cur_sense <= 12'h500;
    cyc(2 * TK);
    chkb(motor_halt, 1'b0);
    cyc(4 * TK);
    chkb(motor_halt, 1'b1);
    rd(8'h38);
    chkv(r & 32'h8, 32'h8);
    cur_sense <= 12'h000;
    wr(8'h00, 32'h0);
    // Open loop only takes effect on a millisecond tick
    cyc(TK + 4);
    wr(8'h00, 32'h1);
    cyc(4);
    chkb(motor_halt, 1'b0);
    wr(8'h00, 32'h101);
    cur_sense <= 12'h500;
    cyc(6 * TK);
    chkb(motor_halt, 1'b1);
    rd(8'h38);
    chkv(r & 32'h4c, 32'h4c);
    cur_sense <= 12'h000;
    cyc(TK + 6);
    chkb(motor_halt, 1'b0);
    $display("test current done");
    stall <= 1'b1;
    wr(8'h00, 32'h11);
    wr(8'h04, 32'hffff_fda8);
    cyc(200 * TK);
    chkb(motor_halt, 1'b0);
    wait_hi(1'b1, 150 * TK);
    rd(8'h38);
    chkv(r & 32'h22, 32'h22);
    wr(8'h00, 32'h0);
    cyc(TK + 4);
    rd(8'h38);
    chkv(r & 32'h20, 32'h0);
    stall <= 1'b0;
    $display("test loop error done");
    wr(8'h00, 32'h9);
    cyc(4);
    chkb(motor_halt, 1'b1);
    home_sw <= 1'b1;
    cyc(4);
    home_sw <= 1'b0;
    cyc(4);
    rd(8'h4c);
    chkv(r, 32'h0);
    chkb(motor_halt, 1'b0);
    for (int i = 0; i < 8; i++) begin
      {enc_a, enc_b} <= (i % 4 == 0) ? 2'h2 : (i % 4 == 1) ? 2'h3 :
                        (i % 4 == 2) ? 2'h1 : 2'h0;
      cyc(4);
    end
    rd(8'h4c);
    q = r;
    chkb(q === 32'h8 || q === 32'hffff_fff8, 1'b1);
    rd(8'h40);
    chkv(r, q);
    $display("test encoder done");
    presetn <= 1'b0;
    cyc(2);
    chkb(motor_halt, 1'b1);
    chkb(irq, 1'b0);
    presetn <= 1'b1;
    rd(8'h1c);
    chkv(r, 32'h10);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
